// ===== src/nand_feature_pkg.sv
// Package: feature addresses, bit fields, opcodes, timing and carrier types
package nand_feature_pkg;
  // Feature command opcodes seen on the serial link
  localparam logic [7:0] OPC_GET   = 8'h0f;
  localparam logic [7:0] OPC_SET   = 8'h1f;
  localparam logic [7:0] OPC_WREN  = 8'h06;
  localparam logic [7:0] OPC_WRDI  = 8'h04;
  localparam logic [7:0] OPC_ERASE = 8'hd8;
  localparam logic [7:0] OPC_PEXEC = 8'h10;
  localparam logic [7:0] OPC_PREAD = 8'h13;
  localparam logic [7:0] OPC_RESET = 8'hff;
  // Frame lengths in serial bits
  localparam logic [5:0] LEN_SHORT = 6'h08;
  localparam logic [5:0] LEN_SET   = 6'h18;
  localparam logic [5:0] LEN_PAGE  = 6'h20;
  localparam logic [5:0] LEN_ADDR  = 6'h10;
  localparam logic [5:0] LEN_NONE  = 6'h00;
  localparam logic [5:0] LEN_MAX   = 6'h3f;
  // Feature addresses
  localparam logic [7:0] CFG_ADDR  = 8'hb0;
  localparam logic [7:0] STAT_ADDR = 8'hc0;
  localparam logic [7:0] SEC0_ADDR = 8'h80;
  localparam logic [7:0] SEC1_ADDR = 8'h84;
  localparam logic [7:0] SEC2_ADDR = 8'h88;
  localparam logic [7:0] SEC3_ADDR = 8'h8c;
  // Configuration register fields
  localparam int CFG_LOCK_BIT   = 7;
  localparam int CFG_ACCESS_BIT = 6;
  localparam int CFG_ECC_BIT    = 4;
  localparam int CFG_DRV_LSB    = 1;
  localparam int CFG_QE_BIT     = 0;
  localparam logic       ECC_EN_RESET = 1'b1;
  localparam logic [1:0] DRV_RESET    = 2'h0;
  // Sector error codes
  localparam logic [3:0] SEC_OK       = 4'h0;
  localparam logic [3:0] SEC_FIXED    = 4'h1;
  localparam logic [2:0] SEC_BAD_HI   = 3'h1;
  // Array geometry
  localparam logic [16:0] OTP_PAGES   = 17'h0003e;
  localparam int PAGE_BYTES   = 2112;
  localparam int SECTORS      = 4;
  localparam int SECTOR_MAIN  = 512;
  localparam int SECTOR_SPARE = 16;
  localparam int SPARE_BASE   = 2048;
  // Soft reset busy time
  localparam int CORE_CLK_KHZ = 40000;
  localparam int T_RST_NS     = 5000;
  localparam int RST_CYCLES   = (T_RST_NS * CORE_CLK_KHZ + 999999) / 1000000;

  typedef enum logic [2:0] {
    OPK_BOOT  = 3'b000,
    OPK_READ  = 3'b001,
    OPK_PROG  = 3'b010,
    OPK_ERASE = 3'b011,
    OPK_LOCK  = 3'b100
  } op_kind_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
  } frame_s;

  typedef struct packed {
    op_kind_e    kind;
    logic [16:0] page;
    logic        otp;
    logic        ecc_en;
  } eng_req_s;

  typedef struct packed {
    logic             done;
    logic             fail;
    logic [3:0][3:0]  sec;
  } eng_rsp_s;
endpackage

// ===== src/nand_feature_status_regs.sv
// Feature, status and sector error registers with serial feature access
`timescale 1ns/1ps
module nand_feature_status_regs (
  input  wire logic                       core_clk_in,        // Core clock, 40 MHz
  input  wire logic                       resetn_in,          // Power-on reset, active low
  input  wire logic                       spi_clk_in,         // Serial link clock
  input  wire logic                       cs_n_in,            // Chip select, active low
  input  wire logic                       si_in,              // Serial data in
  output logic                            so_out,             // Serial data out
  output logic                            so_oe_out,          // Serial out drive enable
  input  wire logic                       prot_hit_in,        // Target block is protected
  output nand_feature_pkg::eng_req_s      eng_req_out,        // Array operation request
  output logic                            eng_start_out,      // Request start pulse
  input  wire nand_feature_pkg::eng_rsp_s eng_rsp_in,         // Array operation result
  output logic [1:0]                      drive_strength_sel_out, // Output drive select
  output logic                            quad_io_enable_out, // Four-line I/O mode
  output logic                            wp_hold_enable_out  // Protect/hold pin functions on
);
  import nand_feature_pkg::*;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_OP   = 2'b10,
    ST_RST  = 2'b11
  } state_e;

  // ---------------- Link clock domain ----------------
  logic        frame_rst;
  logic [5:0]  bit_cnt_q;
  logic [5:0]  bits_d;
  logic [31:0] shift_q;
  logic [31:0] shift_d;
  logic [7:0]  opc_q;
  logic [7:0]  cur_opc;
  logic [5:0]  need_len;
  logic        done_q;
  logic        fire;
  logic        get_phase_q;
  logic [7:0]  tx_q;
  logic        so_q;
  logic        oe_q;
  logic [31:0] fr_word_q;
  logic        fr_tg_q;
  logic [2:0]  img_sy_q;
  logic        img_seen_q;
  logic [47:0] img_q;
  logic        img_tg_q;   // Core-side toggle, caught here by img_sy_q
  logic [47:0] img_hold_q; // Core-side image, steady while the toggle is pending

  // Chip select high ends every frame; the link clock may stop outside frames
  assign frame_rst = cs_n_in | ~resetn_in;
  assign bits_d    = bit_cnt_q + 6'h01;
  assign shift_d   = {shift_q[30:0], si_in};
  assign cur_opc   = (bits_d == LEN_SHORT) ? shift_d[7:0] : opc_q;

  // Frame length per opcode; get feature never hands a frame over
  always_comb begin
    case (cur_opc)
      OPC_GET:   need_len = LEN_NONE;
      OPC_SET:   need_len = LEN_SET;
      OPC_PEXEC,
      OPC_ERASE,
      OPC_PREAD: need_len = LEN_PAGE;
      default:   need_len = LEN_SHORT;
    endcase
  end
  // A saturated counter wraps bits_d to zero; keep long reads from firing a frame
  assign fire = !done_q && (bit_cnt_q != LEN_MAX) && (bits_d == need_len);

  // Input shifter and bit counter, saturating so long reads never wrap
  always_ff @(posedge spi_clk_in or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 6'h00;
      shift_q   <= 32'h0000_0000;
      opc_q     <= 8'h00;
      done_q    <= 1'b0;
    end else begin
      bit_cnt_q <= (bit_cnt_q == LEN_MAX) ? bit_cnt_q : bits_d;
      shift_q   <= shift_d;
      if (bits_d == LEN_SHORT) opc_q <= shift_d[7:0];
      if (fire) done_q <= 1'b1;
    end
  end

  // Completed frame is held for the core and announced by a toggle
  always_ff @(posedge spi_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fr_word_q <= 32'h0000_0000;
      fr_tg_q   <= 1'b0;
    end else if (fire) begin
      case (need_len)
        LEN_SHORT: fr_word_q <= {shift_d[7:0], 24'h000000};
        LEN_SET:   fr_word_q <= {shift_d[23:0], 8'h00};
        default:   fr_word_q <= shift_d;
      endcase
      fr_tg_q <= ~fr_tg_q;
    end
  end

  // Register image mirror; refreshed by handshake, so a poll may lag one frame
  always_ff @(posedge spi_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      img_sy_q   <= 3'h0;
      img_seen_q <= 1'b0;
      img_q      <= 48'h0;
    end else begin
      img_sy_q <= {img_sy_q[1:0], img_tg_q};
      if (img_sy_q[2] != img_seen_q && img_sy_q[1] == img_sy_q[2]) begin
        img_q      <= img_hold_q;
        img_seen_q <= img_sy_q[2];
      end
    end
  end

  // Feature read byte select from the mirrored image
  function automatic logic [7:0] sel_byte(input logic [7:0] addr, input logic [47:0] img);
    case (addr)
      CFG_ADDR:  sel_byte = img[47:40];
      STAT_ADDR: sel_byte = img[39:32];
      SEC0_ADDR: sel_byte = img[31:24];
      SEC1_ADDR: sel_byte = img[23:16];
      SEC2_ADDR: sel_byte = img[15:8];
      SEC3_ADDR: sel_byte = img[7:0];
      default:   sel_byte = 8'h00;
    endcase
  endfunction

  // Get feature answers in the link domain so it works while busy
  always_ff @(posedge spi_clk_in or posedge frame_rst) begin
    if (frame_rst) begin
      get_phase_q <= 1'b0;
      tx_q        <= 8'h00;
    end else if (bits_d == LEN_ADDR && opc_q == OPC_GET) begin
      get_phase_q <= 1'b1;
      tx_q        <= sel_byte(shift_d[7:0], img_q);
    end else if (get_phase_q) begin
      tx_q <= {tx_q[6:0], tx_q[7]}; // Byte repeats while clocked
    end
  end

  // Output changes on the falling edge, ready for the host's rising edge
  always_ff @(negedge spi_clk_in or posedge frame_rst) begin
    if (frame_rst) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      so_q <= tx_q[7];
      oe_q <= get_phase_q;
    end
  end
  assign so_out    = so_q;
  assign so_oe_out = oe_q;

  // ---------------- Core clock domain ----------------
  logic [2:0]       fr_sy_q;
  logic             fr_seen_q;
  logic             fr_new;
  frame_s           cmd;
  logic [2:0]       ack_sy_q;
  logic [47:0]      img_live;
  state_e           state_q;
  logic [7:0]       cnt_q;
  logic             busy;
  logic             acc;
  logic             otp_lock_q;
  logic             otp_access_q;
  logic             ecc_en_q;
  logic [1:0]       drive_q;
  logic             quad_q;
  logic             wel_q;
  logic             p_fail_q;
  logic             e_fail_q;
  logic [3:0][3:0]  sec_q;
  logic [1:0]       ess;
  logic [16:0]      page;
  logic             cfg_wr;
  logic             lock_req;
  logic             prog_bad;
  logic             prog_ok;
  logic             erase_ok;
  logic             start_d;
  op_kind_e         kind_d;
  logic [7:0]       cfg_byte;
  logic [7:0]       stat_byte;
  logic [3:0][7:0]  sec_byte;
  eng_req_s         req_q;
  logic             start_q;

  // Three-stage catch of the frame toggle; act once stages two and three agree
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fr_sy_q   <= 3'h0;
      fr_seen_q <= 1'b0;
      ack_sy_q  <= 3'h0;
    end else begin
      fr_sy_q  <= {fr_sy_q[1:0], fr_tg_q};
      ack_sy_q <= {ack_sy_q[1:0], img_seen_q};
      if (fr_new) fr_seen_q <= fr_sy_q[2];
    end
  end
  assign fr_new = (fr_sy_q[2] != fr_seen_q) && (fr_sy_q[1] == fr_sy_q[2]);
  assign cmd    = frame_s'(fr_word_q); // Stable until the next frame completes

  // Command decode; only reset gets through while busy
  assign busy     = (state_q != ST_IDLE);
  assign acc      = fr_new && (!busy || cmd.opcode == OPC_RESET);
  assign page     = {cmd.b1[0], cmd.b2, cmd.b3};
  assign cfg_wr   = acc && cmd.opcode == OPC_SET && cmd.b1 == CFG_ADDR;
  assign lock_req = cfg_wr && cmd.b2[CFG_LOCK_BIT] && !otp_lock_q;
  // Programs and erases of locked or out-of-range OTP pages and of protected blocks never reach the array; page reads are not checked
  assign prog_bad = otp_access_q ? (otp_lock_q || page >= OTP_PAGES) : prot_hit_in;
  assign prog_ok  = wel_q && !prog_bad;
  assign erase_ok = wel_q && !otp_access_q && !prot_hit_in;

  // Array request selection
  always_comb begin
    start_d = 1'b0;
    kind_d  = OPK_BOOT;
    if (state_q == ST_BOOT) begin
      start_d = 1'b1;
    end else if (acc && state_q == ST_IDLE) begin
      case (cmd.opcode)
        OPC_PEXEC: begin
          start_d = prog_ok;
          kind_d  = OPK_PROG;
        end
        OPC_ERASE: begin
          start_d = erase_ok;
          kind_d  = OPK_ERASE;
        end
        OPC_PREAD: begin
          start_d = 1'b1;
          kind_d  = OPK_READ;
        end
        OPC_SET: begin
          start_d = lock_req;
          kind_d  = OPK_LOCK;
        end
        default: start_d = 1'b0;
      endcase
    end
  end

  // Busy sequencing; soft reset aborts any array operation
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_BOOT;
      cnt_q   <= 8'h00;
    end else begin
      case (state_q)
        ST_BOOT: state_q <= ST_OP;
        ST_IDLE: begin
          if (acc && cmd.opcode == OPC_RESET) begin
            state_q <= ST_RST;
            cnt_q   <= 8'(RST_CYCLES - 1);
          end else if (start_d) begin
            state_q <= ST_OP;
          end
        end
        ST_OP: begin
          if (acc && cmd.opcode == OPC_RESET) begin
            state_q <= ST_RST;
            cnt_q   <= 8'(RST_CYCLES - 1);
          end else if (eng_rsp_in.done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_RST: begin
          if (cnt_q == 8'h00) state_q <= ST_IDLE;
          else cnt_q <= cnt_q - 8'h01;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Array request register
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_q   <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= start_d;
      if (start_d) begin
        req_q.kind   <= kind_d;
        req_q.page   <= (state_q == ST_BOOT) ? 17'h00000 : page;
        req_q.otp    <= otp_access_q && state_q != ST_BOOT;
        req_q.ecc_en <= ecc_en_q;
      end
    end
  end
  assign eng_req_out   = req_q;
  assign eng_start_out = start_q;

  // Configuration bits; the lock is one-way and survives soft reset
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      otp_lock_q   <= 1'b0;
      otp_access_q <= 1'b0;
      ecc_en_q     <= ECC_EN_RESET;
      drive_q      <= DRV_RESET;
      quad_q       <= 1'b0;
    end else if (acc && cmd.opcode == OPC_RESET) begin
      otp_access_q <= 1'b0;
    end else if (cfg_wr) begin
      otp_lock_q   <= otp_lock_q | cmd.b2[CFG_LOCK_BIT];
      otp_access_q <= cmd.b2[CFG_ACCESS_BIT];
      ecc_en_q     <= cmd.b2[CFG_ECC_BIT];
      drive_q      <= cmd.b2[CFG_DRV_LSB +: 2];
      quad_q       <= cmd.b2[CFG_QE_BIT];
    end
  end
  assign drive_strength_sel_out = drive_q;
  assign quad_io_enable_out     = quad_q;
  assign wp_hold_enable_out     = !quad_q;

  // Write latch and failure flags; array results land only outside reset
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wel_q    <= 1'b0;
      p_fail_q <= 1'b0;
      e_fail_q <= 1'b0;
    end else if (acc) begin
      case (cmd.opcode)
        OPC_WREN:  wel_q <= 1'b1;
        OPC_WRDI,
        OPC_PREAD: wel_q <= 1'b0;
        OPC_PEXEC: begin
          wel_q    <= 1'b0;
          p_fail_q <= wel_q && prog_bad;
          e_fail_q <= 1'b0;
        end
        OPC_ERASE: begin
          wel_q    <= 1'b0;
          p_fail_q <= 1'b0;
          e_fail_q <= wel_q && !erase_ok;
        end
        OPC_RESET: begin
          wel_q    <= 1'b0;
          p_fail_q <= 1'b0;
          e_fail_q <= 1'b0;
        end
        default: wel_q <= wel_q;
      endcase
    end else if (state_q == ST_OP && eng_rsp_in.done && eng_rsp_in.fail) begin
      if (req_q.kind == OPK_PROG) p_fail_q <= 1'b1;
      if (req_q.kind == OPK_ERASE) e_fail_q <= 1'b1;
    end
  end

  // Sector error codes from page loads; cleared by reset or with ECC off
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sec_q <= '0;
    end else if (acc && cmd.opcode == OPC_RESET) begin
      sec_q <= '0;
    end else if (state_q == ST_OP && eng_rsp_in.done &&
                 (req_q.kind == OPK_READ || req_q.kind == OPK_BOOT)) begin
      sec_q <= req_q.ecc_en ? eng_rsp_in.sec : '0;
    end
  end

  // Summary: bit 1 flags any uncorrectable sector, bit 0 any corrected one; both can be set
  always_comb begin
    ess = 2'h0;
    for (int i = 0; i < SECTORS; i++) begin
      if (sec_q[i][3:1] == SEC_BAD_HI) ess[1] = 1'b1;
      else if (sec_q[i] == SEC_FIXED) ess[0] = 1'b1;
    end
  end

  // Report bytes: reserved top bits, sector number, four-bit code
  for (genvar g = 0; g < SECTORS; g++) begin : g_sec
    assign sec_byte[g] = {2'h0, 2'(g), sec_q[g]};
  end

  assign cfg_byte  = {otp_lock_q, otp_access_q, 1'b0, ecc_en_q, 1'b0, drive_q, quad_q};
  assign stat_byte = {2'h0, ess, p_fail_q, e_fail_q, wel_q, busy};
  assign img_live  = {cfg_byte, stat_byte, sec_byte[0], sec_byte[1], sec_byte[2], sec_byte[3]};

  // Publish image to the link domain; one transfer in flight at a time
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      img_tg_q   <= 1'b0;
      img_hold_q <= 48'h0;
    end else if (img_tg_q == ack_sy_q[2] && ack_sy_q[1] == ack_sy_q[2] &&
                 img_live != img_hold_q) begin
      img_hold_q <= img_live;
      img_tg_q   <= ~img_tg_q;
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_acc_reset;
    acc && cmd.opcode == OPC_RESET;
  endsequence
  sequence s_op_end;
    state_q == ST_OP ##0 eng_rsp_in.done && !fr_new;
  endsequence

  a_busy_ignores_cmd: assert property ((fr_new && busy && cmd.opcode != OPC_RESET)
    |=> $stable(cfg_byte) && $stable(wel_q)) else $error("command taken while busy");
  a_wel_sets: assert property (acc && cmd.opcode == OPC_WREN |=> wel_q)
    else $error("write latch not set");
  a_wel_clears: assert property (acc && (cmd.opcode == OPC_WRDI || cmd.opcode == OPC_PEXEC
    || cmd.opcode == OPC_ERASE || cmd.opcode == OPC_PREAD) |=> !wel_q)
    else $error("write latch not cleared");
  a_reset_clears_flags: assert property (s_acc_reset |=> !p_fail_q && !e_fail_q
    && ess == 2'h0 && !otp_access_q) else $error("reset left flags set");
  a_reset_keeps_ecc: assert property (s_acc_reset |=> $stable(ecc_en_q))
    else $error("reset changed ecc enable");
  a_otp_lock_blocks: assert property (acc && cmd.opcode == OPC_PEXEC && wel_q
    && otp_access_q && otp_lock_q |=> p_fail_q && !eng_start_out)
    else $error("locked otp program not refused");
  a_summary_bad: assert property (sec_q[0][3:1] == SEC_BAD_HI |-> ess[1])
    else $error("summary misses uncorrectable sector");
  a_op_done_idle: assert property (s_op_end |=> !busy)
    else $error("busy not cleared at completion");
  a_reset_busy: assert property (s_acc_reset |=> busy [*8])
    else $error("soft reset not busy");
endmodule // nand_feature_status_regs

// ===== verification/spi_host_model.sv
// Host side of the serial link: sends feature frames, clock runs only inside frames
`timescale 1ns/1ps
module spi_host_model (
  output logic      spi_clk_out, // Link clock, 160 ns period
  output logic      cs_n_out,    // Chip select, active low
  output logic      si_out,      // Serial data to the device
  input  wire logic so_in,       // Serial data from the device
  input  wire logic so_oe_in     // Device drives so
);
  // Idle link: clock low, deselected
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out    = 1'b1;
    si_out      = 1'b0;
  end
  // One frame of n bits, MSB first; reply bits taken on rising edges after bit 16
  task automatic frame(input logic [31:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #13ns;
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_out = bits[31-i];
      #80ns spi_clk_out = 1'b1;
      if (i >= 16) rd = so_oe_in ? {rd[6:0], so_in} : 8'hxx; // Undriven reply never matches
      #80ns spi_clk_out = 1'b0;
    end
    cs_n_out = 1'b1;
    si_out = ~si_out; // Released line shows no stale value
    #300ns; // Frame spacing well over 8 core cycles
  endtask
endmodule // spi_host_model

// ===== verification/test_nand_feature_status_regs.sv
// Self-checking bench: register model, array engine stand-in, serial host
`timescale 1ns/1ps
module test_nand_feature_status_regs;
  import nand_feature_pkg::*;
  logic            core_clk_in = 1'b0;
  logic            resetn_in   = 1'b0;
  logic            prot_hit_in = 1'b0;
  eng_rsp_s        eng_rsp_in  = '0;
  eng_req_s        eng_req_out;
  logic            eng_start_out, spi_clk, cs_n, si, so, so_oe, quad, wp_hold;
  logic [1:0]      drive;
  int              mismatches  = 0;
  int              checks      = 0;
  int              eng_cnt     = 0;
  int              eng_dly     = 6;
  int              n_ops       = 0;
  int              n0;
  op_kind_e        kind_seen;
  logic [7:0]      lfsr        = 8'h24;
  logic [7:0]      rd, cfg_m;
  logic [3:0][3:0] sec_m, sec_st;
  logic            fail_m = 1'b0;
  logic            pf = 1'b0, ef = 1'b0, write_latch_flag = 1'b0, busy = 1'b0;

  always #12.5ns core_clk_in = ~core_clk_in;

  nand_feature_status_regs i_nand_feature_status_regs (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .spi_clk_in(spi_clk),
    .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe), .prot_hit_in(prot_hit_in),
    .eng_req_out(eng_req_out), .eng_start_out(eng_start_out), .eng_rsp_in(eng_rsp_in),
    .drive_strength_sel_out(drive), .quad_io_enable_out(quad), .wp_hold_enable_out(wp_hold));
  spi_host_model host (.spi_clk_out(spi_clk), .cs_n_out(cs_n), .si_out(si), .so_in(so),
    .so_oe_in(so_oe));

  // Array engine stand-in: answers each start after eng_dly cycles
  always @(posedge core_clk_in) begin
    eng_rsp_in.done <= (eng_cnt == 1) && !eng_start_out;
    eng_rsp_in.fail <= fail_m;
    eng_rsp_in.sec  <= sec_m;
    if (eng_start_out) begin
      eng_cnt   <= eng_dly;
      n_ops     <= n_ops + 1;
      kind_seen <= op_kind_e'(eng_req_out.kind);
    end else if (eng_cnt > 0) eng_cnt <= eng_cnt - 1;
  end

  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Fresh valid sector codes 0000..0011 from the shift register
  task automatic new_codes();
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      sec_m[i] = {2'b00, lfsr[1:0]};
    end
  endtask
  // Summary: any uncorrectable wins over corrected
  function automatic logic [1:0] sum_m();
    logic b, f;
    b = 1'b0;
    f = 1'b0;
    for (int i = 0; i < 4; i++) begin
      b |= sec_st[i][1];
      f |= (sec_st[i] == SEC_FIXED);
    end
    return b ? 2'b10 : {1'b0, f};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [31:0] b, input int n);
    logic [7:0] x;
    host.frame(b, n, x);
  endtask
  // Read twice: the read image trails the core by a few link edges
  task automatic get(input logic [7:0] a);
    host.frame({OPC_GET, a, 16'h0000}, 24, rd);
    host.frame({OPC_GET, a, 16'h0000}, 24, rd);
  endtask
  task automatic chk_st();
    logic [7:0] e;
    get(STAT_ADDR);
    e = {2'b00, sum_m(), pf, ef, write_latch_flag, busy};
    if (e[5]) rd[4] = 1'b0; // Low summary bit is free when uncorrectable
    chk("status", e, rd);
  endtask
  task automatic chk_sec();
    for (int i = 0; i < 4; i++) begin
      get(SEC0_ADDR + 8'(4 * i));
      chk("sector", {2'b00, 2'(i), sec_st[i]}, rd);
    end
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 60; k++) begin
      get(STAT_ADDR);
      if (rd[0] === 1'b0) break;
    end
    if (k == 60) begin
      mismatches++;
      wrap_up();
    end
  endtask

  // Main sequence
  initial begin
    new_codes();
    repeat (10) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    wait_idle();
    sec_st = sec_m;
    chk("boot kind", 8'(OPK_BOOT), 8'(kind_seen));
    chk_sec();
    chk_st();
    cfg_m = 8'h10;
    get(CFG_ADDR);
    chk("cfg reset", cfg_m, rd);
    // Every drive code; quad follows its low bit, access bit on last
    for (int d = 0; d < 4; d++) begin
      cfg_m = 8'h10 | 8'(d << 1) | 8'(d & 1) | (d == 3 ? 8'h40 : 8'h00);
      cmd({OPC_SET, CFG_ADDR, cfg_m, 8'h00}, 24);
      get(CFG_ADDR);
      chk("cfg", cfg_m, rd);
      chk("drive", 8'(d), 8'(drive));
      chk("quad", 8'(cfg_m[0]), 8'(quad));
      chk("wp hold", 8'(!cfg_m[0]), 8'(wp_hold));
    end
    cmd({OPC_WREN, 24'h0}, 8);
    write_latch_flag = 1'b1;
    chk_st();
    cmd({OPC_WRDI, 24'h0}, 8);
    write_latch_flag = 1'b0;
    chk_st();
    // Program into the one-time area beyond its 62 pages
    n0 = n_ops;
    cmd({OPC_WREN, 24'h0}, 8);
    cmd({OPC_PEXEC, 24'h000046}, 32);
    pf = 1'b1;
    chk_st();
    chk("no op", 8'(n0), 8'(n_ops));
    cfg_m[6] = 1'b0;
    cmd({OPC_SET, CFG_ADDR, cfg_m, 8'h00}, 24);
    // Erase of a protected block
    @(posedge core_clk_in) prot_hit_in <= 1'b1;
    cmd({OPC_WREN, 24'h0}, 8);
    cmd({OPC_ERASE, 24'h000040}, 32);
    pf = 1'b0;
    ef = 1'b1;
    chk_st();
    chk("no op", 8'(n0), 8'(n_ops));
    // Slow failing program; write enable during it is dropped
    @(posedge core_clk_in) prot_hit_in <= 1'b0;
    fail_m = 1'b1;
    eng_dly = 2000;
    cmd({OPC_WREN, 24'h0}, 8);
    cmd({OPC_PEXEC, 24'h000005}, 32);
    ef = 1'b0;
    busy = 1'b1;
    chk_st();
    chk("req page", 8'h05, eng_req_out.page[7:0]);
    chk("req ecc", 8'h01, 8'(eng_req_out.ecc_en));
    chk("req otp", 8'h00, 8'(eng_req_out.otp));
    cmd({OPC_WREN, 24'h0}, 8);
    wait_idle();
    busy = 1'b0;
    pf = 1'b1;
    chk("prog kind", 8'(OPK_PROG), 8'(kind_seen));
    chk_st();
    // Page read stores new sector codes
    fail_m = 1'b0;
    eng_dly = 6;
    new_codes();
    cmd({OPC_WREN, 24'h0}, 8);
    cmd({OPC_PREAD, 24'h000000}, 32);
    write_latch_flag = 1'b0;
    wait_idle();
    sec_st = sec_m;
    chk_st();
    chk_sec();
    // Soft reset with access bit on
    cfg_m[6] = 1'b1;
    cfg_m[4] = 1'b0; // ECC off, so a reset that forces it on is seen
    cmd({OPC_SET, CFG_ADDR, cfg_m, 8'h00}, 24);
    cmd({OPC_RESET, 24'h0}, 8);
    wait_idle();
    cfg_m[6] = 1'b0;
    pf = 1'b0;
    sec_st = '0;
    get(CFG_ADDR);
    chk("cfg after reset", cfg_m, rd);
    chk("quad kept", 8'(cfg_m[0]), 8'(quad));
    chk_st();
    chk_sec();
    // Status is read-only; unmapped address reads zero
    cmd({OPC_SET, STAT_ADDR, 8'hff, 8'h00}, 24);
    chk_st();
    get(8'h00);
    chk("unmapped", 8'h00, rd);
    // Lock the one-time area; the lock is sticky and refuses later programs
    cfg_m[7] = 1'b1;
    cmd({OPC_SET, CFG_ADDR, cfg_m, 8'h00}, 24);
    wait_idle();
    chk("lock kind", 8'(OPK_LOCK), 8'(kind_seen));
    cfg_m[6] = 1'b1;
    cmd({OPC_SET, CFG_ADDR, cfg_m & 8'h7f, 8'h00}, 24);
    get(CFG_ADDR);
    chk("cfg locked", cfg_m, rd);
    n0 = n_ops;
    cmd({OPC_WREN, 24'h0}, 8);
    cmd({OPC_PEXEC, 24'h000001}, 32);
    pf = 1'b1;
    chk_st();
    chk("no op", 8'(n0), 8'(n_ops));
    wrap_up();
  end
endmodule // test_nand_feature_status_regs
